/* File: src/device_config_error_status.sv */
`timescale 1ns/1ps
`include "dev_status_consts.svh"


module device_config_error_status
    import dev_status_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic [4:0]  memFault,
    input  wire logic        unknownUnit,
    input  wire logic [5:0]  registeredCount,
    input  wire logic [5:0]  connectedCount,
    input  wire logic        configRegistered,
    input  wire logic        registeredRecognised,
    input  wire logic        startupFault,
    input  wire logic        leftSideUnit,
    input  wire logic        peersOperating,
    input  wire logic        registerStrobe,
    input  wire logic        groupInvalid,
    input  wire logic [15:0] unitFault
);

    top_state_type          stateQ;
    top_state_type          stateD;
    status_word_if          words ();
    word_type               summary;
    logic [5:0]             index;
    logic                   request;
    logic                   writeTaken;
    logic [`EVT_WIDTH-1:0]  newEvent;
    logic [`EVT_WIDTH-1:0]  clearBits;
    logic                   maskWrite;
    logic [`EVT_WIDTH-1:0]  evtStatus;
    logic [`EVT_WIDTH-1:0]  evtMask;
    logic [31:0]            readValue;

    // ------------------------------------------------------------
    // Fault word sources and event capture
    // ------------------------------------------------------------
    config_fault_eval u_eval (
        .core_clk             (core_clk),
        .rst                  (rst),
        .memFault             (memFault),
        .unknownUnit          (unknownUnit),
        .registeredCount      (registeredCount),
        .connectedCount       (connectedCount),
        .configRegistered     (configRegistered),
        .registeredRecognised (registeredRecognised),
        .startupFault         (startupFault),
        .leftSideUnit         (leftSideUnit),
        .peersOperating       (peersOperating),
        .registerStrobe       (registerStrobe),
        .groupInvalid         (groupInvalid),
        .unitFault            (unitFault),
        .words                (words.producer)
    );

    status_event_bank #(.W(`EVT_WIDTH)) u_events (
        .core_clk  (core_clk),
        .rst       (rst),
        .setEvent  (newEvent),
        .clearBits (clearBits),
        .maskWrite (maskWrite),
        .maskData  (writedata[`EVT_WIDTH-1:0]),
        .status    (evtStatus),
        .mask      (evtMask),
        .irq       (irq)
    );

    // ------------------------------------------------------------
    // Summary word and newly raised fault events
    // ------------------------------------------------------------
    always_comb begin
        summary = `WORD_RESET;
        summary[`SUM_DEVICE_BIT] = |words.memWord;
        summary[`SUM_CONFIG_BIT] = (|words.cfgWord) | (|words.unitWord);
        newEvent = `EVT_RESET;
        newEvent[`EVT_MEM_BIT]  = |(words.memWord & ~stateQ.memPrev);
        newEvent[`EVT_CFG_BIT]  = |(words.cfgWord & ~stateQ.cfgPrev);
        newEvent[`EVT_UNIT_BIT] = |(words.unitWord & ~stateQ.unitPrev);
    end

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, answer on the second cycle
    // ------------------------------------------------------------
    assign index       = address[7:2];
    assign request     = read | write;
    assign waitrequest = request & ~stateQ.respPending;
    assign writeTaken  = write & stateQ.respPending;
    assign readdata    = stateQ.readData;

    always_comb begin
        readValue = `RDATA_RESET;
        if (index == `IDX_SUMMARY) begin
            readValue[15:0] = summary;
        end else if (index == `IDX_MEMORY) begin
            readValue[15:0] = words.memWord;
        end else if (index == `IDX_CONFIG) begin
            readValue[15:0] = words.cfgWord;
        end else if (index == `IDX_UNIT) begin
            readValue[15:0] = words.unitWord;
        end else if (index == `IDX_EVENT) begin
            readValue[`EVT_WIDTH-1:0] = evtStatus;
        end else if (index == `IDX_MASK) begin
            readValue[`EVT_WIDTH-1:0] = evtMask;
        end
    end

    // Only the event and mask registers accept writes
    always_comb begin
        clearBits = `EVT_RESET;
        maskWrite = 1'b0;
        if (writeTaken && byteenable[0]) begin
            if (index == `IDX_EVENT) begin
                clearBits = writedata[`EVT_WIDTH-1:0];
            end else if (index == `IDX_MASK) begin
                maskWrite = 1'b1;
            end
        end
    end

    always_comb begin
        stateD = stateQ;
        stateD.memPrev  = words.memWord;
        stateD.cfgPrev  = words.cfgWord;
        stateD.unitPrev = words.unitWord;
        if (request && !stateQ.respPending) begin
            stateD.respPending = 1'b1;
            stateD.readData    = read ? readValue : `RDATA_RESET;
        end else begin
            stateD.respPending = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

endmodule : device_config_error_status

/* File: include/dev_status_consts.svh */
`ifndef DEV_STATUS_CONSTS_SVH
`define DEV_STATUS_CONSTS_SVH

// ------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_SUMMARY       6'h00
`define IDX_MEMORY        6'h01
`define IDX_CONFIG        6'h02
`define IDX_UNIT          6'h03
`define IDX_EVENT         6'h10
`define IDX_MASK          6'h11

// ------------------------------------------------------------
// Memory fault word bit positions
// ------------------------------------------------------------
`define MEM_NVM_BIT       4
`define MEM_SETTING_BIT   6
`define MEM_REGDATA_BIT   8
`define MEM_MODEL_BIT     9
`define MEM_MISMATCH_BIT  12

// ------------------------------------------------------------
// Configuration fault word bit positions
// ------------------------------------------------------------
`define CFG_UNKNOWN_BIT   0
`define CFG_NOUNIT_BIT    1
`define CFG_TOOMANY_BIT   2
`define CFG_CONNECT_BIT   4
`define CFG_STARTUP_BIT   5
`define CFG_LEFTSIDE_BIT  8
`define CFG_RESTART_BIT   12
`define CFG_EMPTYREG_BIT  13
`define CFG_GROUP_BIT     14

// ------------------------------------------------------------
// Summary word, events, limits and reset values
// ------------------------------------------------------------
`define SUM_DEVICE_BIT    0
`define SUM_CONFIG_BIT    1
`define EVT_MEM_BIT       0
`define EVT_CFG_BIT       1
`define EVT_UNIT_BIT      2
`define EVT_WIDTH         3
`define MAX_UNITS         6'd16
`define WORD_RESET        16'h0000
`define EVT_RESET         3'h0
`define RDATA_RESET       32'h0000_0000

`endif

/* File: include/dev_status_pkg.sv */
package dev_status_pkg;

    typedef logic [15:0] word_type;

    typedef struct packed {
        logic     firstCycle;
        logic     restartFault;
        logic     emptyRegistration;
    } cfg_state_type;

    typedef struct packed {
        logic        respPending;
        logic [31:0] readData;
        word_type    memPrev;
        word_type    cfgPrev;
        word_type    unitPrev;
    } top_state_type;

endpackage : dev_status_pkg

/* File: include/status_word_if.sv */
`timescale 1ns/1ps

interface status_word_if;
    logic [15:0] memWord;
    logic [15:0] cfgWord;
    logic [15:0] unitWord;

    modport producer (output memWord, output cfgWord, output unitWord);
    modport consumer (input memWord, input cfgWord, input unitWord);
endinterface : status_word_if

/* File: src/config_fault_eval.sv */
`timescale 1ns/1ps
`include "dev_status_consts.svh"

module config_fault_eval
    import dev_status_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  memFault,
    input  wire logic        unknownUnit,
    input  wire logic [5:0]  registeredCount,
    input  wire logic [5:0]  connectedCount,
    input  wire logic        configRegistered,
    input  wire logic        registeredRecognised,
    input  wire logic        startupFault,
    input  wire logic        leftSideUnit,
    input  wire logic        peersOperating,
    input  wire logic        registerStrobe,
    input  wire logic        groupInvalid,
    input  wire logic [15:0] unitFault,
    status_word_if.producer  words
);

    cfg_state_type stateQ;
    cfg_state_type stateD;
    word_type      mem;
    word_type      cfg;

    // ------------------------------------------------------------
    // Sticky conditions
    // ------------------------------------------------------------
    always_comb begin
        stateD = stateQ;
        stateD.firstCycle = 1'b0;
        // A lone restart shows as peers still running at reset release
        if (stateQ.firstCycle) begin
            stateD.restartFault = peersOperating;
        end else begin
            stateD.restartFault = stateQ.restartFault & peersOperating;
        end
        if (registerStrobe) begin
            stateD.emptyRegistration = (connectedCount == 6'd0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateQ <= '{firstCycle: 1'b1, restartFault: 1'b0, emptyRegistration: 1'b0};
        end else begin
            stateQ <= stateD;
        end
    end

    // ------------------------------------------------------------
    // Word assembly, unused bits stay zero
    // ------------------------------------------------------------
    always_comb begin
        mem = `WORD_RESET;
        mem[`MEM_NVM_BIT]      = memFault[0];
        mem[`MEM_SETTING_BIT]  = memFault[1];
        mem[`MEM_REGDATA_BIT]  = memFault[2];
        mem[`MEM_MODEL_BIT]    = memFault[3];
        mem[`MEM_MISMATCH_BIT] = memFault[4];
        cfg = `WORD_RESET;
        cfg[`CFG_UNKNOWN_BIT]  = unknownUnit;
        cfg[`CFG_NOUNIT_BIT]   = (registeredCount == 6'd0) && (connectedCount == 6'd0);
        cfg[`CFG_TOOMANY_BIT]  = connectedCount > `MAX_UNITS;
        cfg[`CFG_CONNECT_BIT]  = configRegistered & ~registeredRecognised;
        cfg[`CFG_STARTUP_BIT]  = startupFault;
        cfg[`CFG_LEFTSIDE_BIT] = leftSideUnit;
        cfg[`CFG_RESTART_BIT]  = stateQ.restartFault;
        cfg[`CFG_EMPTYREG_BIT] = stateQ.emptyRegistration;
        cfg[`CFG_GROUP_BIT]    = groupInvalid;
    end

    assign words.memWord  = mem;
    assign words.cfgWord  = cfg;
    assign words.unitWord = configRegistered ? unitFault : `WORD_RESET;

endmodule : config_fault_eval

/* File: src/status_event_bank.sv */
`timescale 1ns/1ps
`include "dev_status_consts.svh"

module status_event_bank #(
    parameter int W = 3
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] setEvent,
    input  wire logic [W-1:0] clearBits,
    input  wire logic         maskWrite,
    input  wire logic [W-1:0] maskData,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic              irq
);

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] mask;
    } evt_state_type;

    evt_state_type stateQ;
    evt_state_type stateD;

    // ------------------------------------------------------------
    // Sticky bits, a new event wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        stateD = stateQ;
        stateD.status = (stateQ.status & ~clearBits) | setEvent;
        if (maskWrite) begin
            stateD.mask = maskData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign status = stateQ.status;
    assign mask   = stateQ.mask;
    assign irq    = |(stateQ.status & stateQ.mask);

endmodule : status_event_bank

/* File: tb/host_model.sv */
`timescale 1ns/1ps

module host_model (
    input  wire logic        core_clk,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    output logic      [7:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    // ------------
    // Register bus master
    // ------------
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
    end

    task automatic busRead(input logic [7:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        @(posedge core_clk);
        while (waitrequest) @(posedge core_clk);
        d = readdata;
        read <= 1'b0;
        @(posedge core_clk);
    endtask : busRead

    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge core_clk);
        while (waitrequest) @(posedge core_clk);
        write <= 1'b0;
        @(posedge core_clk);
    endtask : busWrite

    // Byte lanes for the next transfer, changed only between transfers
    task automatic setLanes(input logic [3:0] be);
        byteenable <= be;
    endtask : setLanes
endmodule : host_model

/* File: tb/device_config_error_status_asserts.sv */
`timescale 1ns/1ps
`include "dev_status_consts.svh"

module status_checker
    import dev_status_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    input wire logic [4:0]  memFault,
    input wire logic        unknownUnit,
    input wire logic [5:0]  registeredCount,
    input wire logic [5:0]  connectedCount,
    input wire logic        configRegistered,
    input wire logic        registeredRecognised,
    input wire logic        startupFault,
    input wire logic        leftSideUnit,
    input wire logic        peersOperating,
    input wire logic        registerStrobe,
    input wire logic        groupInvalid,
    input wire logic [15:0] unitFault
);
    // ------------
    // Wait-state timing, and read answers against the fault inputs
    // ------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire rdGo  = read && waitrequest;
    wire sumRd = rdGo && address[7:2] == `IDX_SUMMARY;
    wire memRd = rdGo && address[7:2] == `IDX_MEMORY;
    wire cfgRd = rdGo && address[7:2] == `IDX_CONFIG;
    wire untRd = rdGo && address[7:2] == `IDX_UNIT;

    AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait state");
    AST_MEM_WORD: assert property (memRd |=> readdata == {19'h0, $past(memFault[4]),
        2'h0, $past(memFault[3:2]), 1'b0, $past(memFault[1]), 1'b0, $past(memFault[0]), 4'h0})
        else $error("memory fault word wrong");
    AST_CFG_DIRECT: assert property (cfgRd |=> readdata[0] == $past(unknownUnit)
        && readdata[5] == $past(startupFault) && readdata[8] == $past(leftSideUnit)
        && readdata[14] == $past(groupInvalid)) else $error("direct fault bit wrong");
    AST_CFG_COUNT: assert property (cfgRd |=> readdata[2] == ($past(connectedCount) > 16)
        && readdata[1] == ($past(connectedCount) == 0 && $past(registeredCount) == 0))
        else $error("unit count fault bit wrong");
    AST_CFG_CONNECT: assert property (cfgRd |=>
        readdata[4] == ($past(configRegistered) && !$past(registeredRecognised)))
        else $error("connection fault bit wrong");
    AST_RESTART_CLR: assert property (cfgRd && !peersOperating && !$past(peersOperating)
        |=> !readdata[12]) else $error("lone restart bit not cleared");
    AST_UNIT_WORD: assert property (untRd |=> readdata ==
        {16'h0, $past(configRegistered) ? $past(unitFault) : 16'h0000})
        else $error("per-unit word wrong");
    AST_SUMMARY: assert property (sumRd && (unknownUnit || startupFault || leftSideUnit
        || groupInvalid) |=> readdata[1]) else $error("summary config bit missing");
    AST_CFG_UNUSED: assert property (cfgRd |=> (readdata & 32'hffff_8ec8) == 32'h0)
        else $error("unused config bit set");
endmodule : status_checker

bind device_config_error_status status_checker u_chk (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "dev_status_consts.svh"

module testbench;
    logic        core_clk, rst, read, write, waitrequest, irq, unknownUnit, configRegistered;
    logic        registeredRecognised, startupFault, leftSideUnit, peersOperating;
    logic        registerStrobe, groupInvalid, restartExp, emptyExp;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [4:0]  memFault;
    logic [5:0]  registeredCount, connectedCount;
    logic [15:0] unitFault;
    logic [31:0] writedata, readdata, d, r, seed;
    logic [31:0] rd [4];
    int          nErrors, testsRun;

    device_config_error_status u_dut (.*);
    host_model u_host (.*);

    // ------------
    // Expectations
    // ------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [15:0] expMem();
        expMem = 16'h0000;
        {expMem[12], expMem[9], expMem[8], expMem[6], expMem[4]} = memFault;
    endfunction : expMem

    function automatic logic [15:0] expCfg();
        expCfg = 16'h0000;
        expCfg[0] = unknownUnit;
        expCfg[1] = registeredCount == 6'h00 && connectedCount == 6'h00;
        expCfg[2] = connectedCount > 6'h10;
        expCfg[4] = configRegistered & ~registeredRecognised;
        expCfg[5] = startupFault;
        expCfg[8] = leftSideUnit;
        expCfg[12] = restartExp;
        expCfg[13] = emptyExp;
        expCfg[14] = groupInvalid;
    endfunction : expCfg

    function automatic logic [15:0] expUnit();
        return configRegistered ? unitFault : 16'h0000;
    endfunction : expUnit

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic checkAll();
        for (int i = 0; i < 4; i++) u_host.busRead(8'(4 * i), rd[i]);
        check(rd[0], 32'({(expCfg() | expUnit()) != 16'h0000, |memFault}));
        check(rd[1], 32'(expMem()));
        check(rd[2], 32'(expCfg()));
        check(rd[3], 32'(expUnit()));
    endtask : checkAll

    task automatic results();
        $display("errors %0d checks %0d", nErrors, testsRun);
        if (nErrors == 0 && testsRun > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    // ------------
    // Stimulus
    // ------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        results();
    end

    initial begin
        {rst, peersOperating, restartExp} = 3'h7;
        {memFault, unknownUnit, startupFault, leftSideUnit, groupInvalid} = 9'h000;
        {configRegistered, registeredRecognised, registerStrobe, emptyExp} = 4'h0;
        {registeredCount, connectedCount, unitFault} = 28'h0;
        {nErrors, testsRun, seed} = {32'h0, 32'h0, 32'h12};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        checkAll();
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            {registeredRecognised, configRegistered, peersOperating} <= r[11:9];
            {groupInvalid, leftSideUnit, startupFault, unknownUnit, memFault} <= r[8:0];
            registerStrobe <= r[12] | (i == 3);
            registeredCount <= (i == 3) ? 6'h00 : 6'(r[14:13]);
            connectedCount <= (i < 3) ? 6'(15 + i) : (i == 3) ? 6'h00 : 6'(r[31:16] % 20);
            unitFault <= 16'(rnd());
            @(posedge core_clk);
            if (registerStrobe) emptyExp = connectedCount == 6'h00;
            restartExp &= peersOperating;
            registerStrobe <= 1'b0;
            @(posedge core_clk);
            checkAll();
        end
        for (int i = 0; i < 4; i++) u_host.busWrite(8'(4 * i), 32'hffff_ffff);
        checkAll();
        u_host.busRead(8'h20, d);
        check(d, 32'h0000_0000);
        {memFault, unknownUnit, startupFault, leftSideUnit, groupInvalid} <= 9'h000;
        u_host.busWrite(8'h44, 32'h0000_0007);
        u_host.busWrite(8'h40, 32'h0000_0007);
        check(32'(irq), 32'h0000_0000);
        memFault <= 5'h01;
        repeat (3) @(posedge core_clk);
        check(32'(irq), 32'h0000_0001);
        u_host.busRead(8'h40, d);
        check(d, 32'h0000_0001);
        u_host.busWrite(8'h40, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        u_host.busWrite(8'h44, 32'h0000_0000);
        memFault <= 5'h03;
        repeat (3) @(posedge core_clk);
        check(32'(irq), 32'h0000_0000);
        u_host.busRead(8'h40, d);
        check(d, 32'h0000_0001);
        // New memory fault lands on the very edge that takes the clear
        fork
            u_host.busWrite(8'h40, 32'h0000_0001);
            begin
                @(posedge core_clk);
                memFault <= 5'h07;
            end
        join
        u_host.busRead(8'h40, d);
        check(d, 32'h0000_0001);
        // Mask write with lane 0 off must leave the mask alone
        u_host.setLanes(4'he);
        u_host.busWrite(8'h44, 32'h0000_0007);
        u_host.setLanes(4'hf);
        u_host.busRead(8'h44, d);
        check(d, 32'h0000_0000);
        u_host.busWrite(8'h44, 32'h0000_0005);
        u_host.busRead(8'h44, d);
        check(d, 32'h0000_0005);
        check(32'(irq), 32'h0000_0001);
        // Second reset while the other units keep running
        rst <= 1'b1;
        peersOperating <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        {restartExp, emptyExp} = 2'h2;
        repeat (2) @(posedge core_clk);
        check(32'(irq), 32'h0000_0000);
        checkAll();
        results();
    end
endmodule : testbench
